/* hdl/lsd_pkg.sv */
// constants, types and field layout of the serial command decoder
// ============================================================
package lsd_pkg;

    // ============================================================
    // timing
    localparam int CLK_HZ         = 25_000_000;
    localparam int BUSY_TIME_NS   = 40_000;
    localparam int BUSY_CYC       = (BUSY_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int BLINK_BASE_MS  = 250;
    localparam int BLINK_BASE_CYC = BLINK_BASE_MS * (CLK_HZ / 1000);

    // ============================================================
    // frame field positions
    localparam int F_SEL_HI  = 7;
    localparam int F_OP_HI   = 7;
    localparam int F_ADDR_HI = 5;
    localparam int F_DDA_HI  = 3;
    localparam int F_SC      = 3;
    localparam int F_RL      = 2;
    localparam int F_PORTSEL = 9;
    localparam int F_PAT_HI  = 8;
    localparam int F_LED_HI  = 5;
    localparam int F_TXT_HI  = 7;
    localparam int F_GLY_HI  = 4;

    // ============================================================
    // opcode values and reset values
    localparam logic [1:0] OP_GLYPH_ADDR = 2'h3;
    localparam logic [1:0] OP_TEXT_ADDR  = 2'h2;
    localparam logic [3:0] OP_CUR_SHIFT  = 4'h1;
    localparam logic [5:0] ADDR_RST      = 6'h00;
    localparam logic [5:0] LED_RST       = 6'h00;

    // ============================================================
    // types
    typedef enum logic [1:0] {
        PAT_STEADY = 2'h0,
        PAT_B05    = 2'h1,
        PAT_B10    = 2'h2,
        PAT_B20    = 2'h3
    } lsd_pat_t;

    typedef enum logic {
        TGT_TEXT  = 1'b0,
        TGT_GLYPH = 1'b1
    } lsd_tgt_t;

    typedef struct packed {
        logic xfer_type;
        logic rd_wr;
        logic reg_sel;
    } lsd_ctl_t;

endpackage

/* hdl/lsd_decoder.sv */
// serial instruction decoder with RAM, LED port, input port and key reads
`timescale 1ns/1ns
`default_nettype none
module lsd_decoder
    import lsd_pkg::*;
#(
    parameter int BLINK_BASE_CYC_P = BLINK_BASE_CYC,
    parameter int BUSY_CYC_P       = BUSY_CYC
)
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // serial link
    input  wire logic       cs_n,
    input  wire logic       scl,
    input  wire logic       register_select_line,
    input  wire logic       rd_wr_line,
    input  wire logic       transfer_type_bit,
    input  wire logic       serial_data_line_in,
    output logic            serial_data_line_out,
    output logic            serial_data_line_oe,
    // ports
    input  wire logic [7:0] input_port_lines,
    input  wire logic [3:0] key_drive_flags,
    input  wire logic [7:0] key_sense_flags,
    output logic      [5:0] led_output_lines,
    // entry mode and status
    input  wire logic       entry_increment,
    input  wire logic       entry_shift,
    output logic            display_shift_pulse,
    output logic            busy_flag,
    output logic      [5:0] address_counter
);

    // ============================================================
    // elaboration checks
    generate
        if (BLINK_BASE_CYC_P < 2)
        begin : g_chk_blink
            $error("blink base count must be at least 2");
        end
        if (BUSY_CYC_P < 1)
        begin : g_chk_busy
            $error("busy count must be at least 1");
        end
    endgenerate

    localparam int BCW = $clog2(BLINK_BASE_CYC_P + 1);
    localparam int KCW = $clog2(BUSY_CYC_P + 1);
    localparam logic [BCW-1:0] BLINK_LAST = BCW'(BLINK_BASE_CYC_P - 1);
    localparam logic [KCW-1:0] BUSY_LOAD  = KCW'(BUSY_CYC_P);

    // ============================================================
    // state
    logic            cs_n_q;
    logic            scl_q;
    lsd_ctl_t        ctl_q;
    logic [15:0]     rx_q;
    logic [15:0]     tx_q;
    logic [5:0]      addr_cnt_q;
    lsd_tgt_t        tgt_q;
    logic [7:0]      text_mem [16];
    logic [4:0]      glyph_mem [64];
    lsd_pat_t        pat_q;
    logic [5:0]      led_q;
    logic [5:0]      led_out_q;
    logic [BCW-1:0]  blink_cnt_q;
    logic [2:0]      phase_q;
    logic [KCW-1:0]  busy_cnt_q;
    logic            shift_q;

    // step the address counter one place
    function automatic logic [5:0] addr_step(input logic [5:0] a, input logic up);
        addr_step = up ? a + 6'h01 : a - 6'h01;
    endfunction

    // ============================================================
    // link edge detection
    logic cs_fall;
    logic cs_rise;
    logic scl_rise;
    logic scl_fall;
    logic busy;

    assign cs_fall  = cs_n_q & ~cs_n;
    assign cs_rise  = ~cs_n_q & cs_n;
    assign scl_rise = ~scl_q & scl & ~cs_n;
    assign scl_fall = scl_q & ~scl & ~cs_n;
    assign busy     = busy_cnt_q != '0;

    // previous pin levels
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cs_n_q <= 1'b1;
            scl_q  <= 1'b0;
        end
        else
        begin
            cs_n_q <= cs_n;
            scl_q  <= scl;
        end
    end

    // control lines are taken as chip select falls
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            ctl_q <= '0;
        else if (cs_fall)
            ctl_q <= '{transfer_type_bit, rd_wr_line, register_select_line};
    end

    // receive shift register, msb first, last sixteen kept
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            rx_q <= '0;
        else if (cs_fall)
            rx_q <= '0;
        else if (scl_rise)
            rx_q <= {rx_q[14:0], serial_data_line_in};
    end

    // ============================================================
    // instruction decode at chip select rise
    logic do_gaddr;
    logic do_taddr;
    logic do_cshift;
    logic do_wdata;
    logic do_led;
    logic do_rdata;
    logic do_any_wr;

    always_comb
    begin
        do_gaddr  = 1'b0;
        do_taddr  = 1'b0;
        do_cshift = 1'b0;
        do_wdata  = 1'b0;
        do_led    = 1'b0;
        do_rdata  = 1'b0;
        if (cs_rise && !busy)
        begin
            if (!ctl_q.rd_wr && !ctl_q.xfer_type)
            begin
                if (!ctl_q.reg_sel)
                begin
                    if (rx_q[F_SEL_HI -: 2] == OP_GLYPH_ADDR)
                        do_gaddr = 1'b1;
                    else if (rx_q[F_SEL_HI -: 2] == OP_TEXT_ADDR)
                        do_taddr = 1'b1;
                    else if (rx_q[F_OP_HI -: 4] == OP_CUR_SHIFT && !rx_q[F_SC])
                        do_cshift = 1'b1;
                end
                else if (!rx_q[F_PORTSEL])
                    do_wdata = 1'b1;
                else
                    do_led = 1'b1;
            end
            else if (ctl_q.rd_wr && ctl_q.xfer_type && ctl_q.reg_sel)
                do_rdata = 1'b1;
        end
    end

    assign do_any_wr = do_gaddr | do_taddr | do_cshift | do_wdata | do_led;

    // ============================================================
    // address counter and RAM target
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            addr_cnt_q <= ADDR_RST;
            tgt_q      <= TGT_TEXT;
        end
        else if (do_gaddr)
        begin
            addr_cnt_q <= rx_q[F_ADDR_HI:0];
            tgt_q      <= TGT_GLYPH;
        end
        else if (do_taddr)
        begin
            addr_cnt_q <= {2'h0, rx_q[F_DDA_HI:0]};
            tgt_q      <= TGT_TEXT;
        end
        else if (do_cshift)
        begin
            addr_cnt_q <= addr_step(addr_cnt_q, rx_q[F_RL]);
            tgt_q      <= TGT_TEXT;
        end
        else if (do_wdata || do_rdata)
            addr_cnt_q <= addr_step(addr_cnt_q, entry_increment);
    end

    // RAM writes, width chosen by target
    always_ff @(posedge clk_sys)
    begin
        if (do_wdata)
        begin
            if (tgt_q == TGT_TEXT)
                text_mem[addr_cnt_q[3:0]] <= rx_q[F_TXT_HI:0];
            else
                glyph_mem[addr_cnt_q] <= rx_q[F_GLY_HI:0];
        end
    end

    // display shift only after text RAM writes, never after reads
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            shift_q <= 1'b0;
        else
            shift_q <= do_wdata & entry_shift & (tgt_q == TGT_TEXT);
    end

    // busy timer started by every accepted write instruction
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            busy_cnt_q <= '0;
        else if (do_any_wr)
            busy_cnt_q <= BUSY_LOAD;
        else if (busy)
            busy_cnt_q <= busy_cnt_q - KCW'(1);
    end

    // ============================================================
    // read word, built from pins as chip select falls
    logic [15:0] rd_word;

    always_comb
    begin
        rd_word = 16'h0000;
        if (rd_wr_line)
        begin
            if (!transfer_type_bit && !register_select_line)
                rd_word = {8'h00, input_port_lines};
            else if (!transfer_type_bit && register_select_line)
                rd_word = {4'h0, key_drive_flags, key_sense_flags};
            else if (transfer_type_bit && !register_select_line)
                rd_word = {9'h000, busy, addr_cnt_q};
            else if (tgt_q == TGT_TEXT)
                rd_word = {8'h00, text_mem[addr_cnt_q[3:0]]};
            else
                rd_word = {11'h000, glyph_mem[addr_cnt_q]};
        end
    end

    // transmit holding register, shifted on clock fall
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            tx_q <= '0;
        else if (cs_fall)
            tx_q <= rd_word;
        else if (scl_fall)
            tx_q <= {tx_q[14:0], 1'b0};
    end

    assign serial_data_line_out = tx_q[15];
    assign serial_data_line_oe  = ~cs_n & ~cs_n_q & ctl_q.rd_wr;

    // ============================================================
    // LED port register
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            pat_q <= PAT_STEADY;
            led_q <= LED_RST;
        end
        else if (do_led)
        begin
            pat_q <= lsd_pat_t'(rx_q[F_PAT_HI -: 2]);
            led_q <= rx_q[F_LED_HI:0];
        end
    end

    // blink time base: phase bit n toggles every 2^n base periods
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            blink_cnt_q <= '0;
            phase_q     <= 3'h0;
        end
        else if (blink_cnt_q == BLINK_LAST)
        begin
            blink_cnt_q <= '0;
            phase_q     <= phase_q + 3'h1;
        end
        else
            blink_cnt_q <= blink_cnt_q + BCW'(1);
    end

    // pattern gate on the output lines
    logic lit;

    always_comb
    begin
        case (pat_q)
            PAT_STEADY: lit = 1'b1;
            PAT_B05:    lit = ~phase_q[0];
            PAT_B10:    lit = ~phase_q[1];
            default:    lit = ~phase_q[2];
        endcase
    end

    // registered LED drive
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            led_out_q <= LED_RST;
        else
            led_out_q <= led_q & {6{lit}};
    end

    // ============================================================
    // outputs
    assign led_output_lines    = led_out_q;
    assign display_shift_pulse = shift_q;
    assign busy_flag           = busy;
    assign address_counter     = addr_cnt_q;

endmodule
`default_nettype wire

/* testbench/lsd_decoder_monitor.sv */
// assertion checker for the serial command decoder
`timescale 1ns/1ns
`default_nettype none
module lsd_decoder_mon
    import lsd_pkg::*;
#(
    parameter int BLINK_BASE_CYC_P = 4,
    parameter int BUSY_CYC_P       = 400
)
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    // serial link
    input wire logic       cs_n,
    input wire logic       scl,
    input wire logic       register_select_line,
    input wire logic       rd_wr_line,
    input wire logic       transfer_type_bit,
    input wire logic       serial_data_line_in,
    input wire logic       serial_data_line_out,
    input wire logic       serial_data_line_oe,
    // ports
    input wire logic [7:0] input_port_lines,
    input wire logic [3:0] key_drive_flags,
    input wire logic [7:0] key_sense_flags,
    input wire logic [5:0] led_output_lines,
    // entry mode and status
    input wire logic       entry_increment,
    input wire logic       entry_shift,
    input wire logic       display_shift_pulse,
    input wire logic       busy_flag,
    input wire logic [5:0] address_counter
);
    // ============================================================
    // cycles spent busy
    int busy_cnt_q;
    always_ff @(posedge clk_sys)
    begin
        if (!nrst || !busy_flag)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= busy_cnt_q + 1;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // ============================================================
    // properties
    a_busy_len: assert property ($fell(busy_flag) |-> busy_cnt_q == BUSY_CYC_P)
        else $error("busy length wrong");
    a_busy_cause: assert property ($rose(busy_flag) |-> $past(cs_n) && !$past(cs_n, 2))
        else $error("busy without frame end");
    a_addr_moment: assert property ($changed(address_counter) |-> $past(cs_n) && !$past(cs_n, 2))
        else $error("address moved mid frame");
    a_addr_step: assert property ($changed(address_counter) && $past(register_select_line)
        |-> address_counter == 6'($past(address_counter) + ($past(entry_increment) ? 6'h01 : 6'h3f)))
        else $error("address step wrong");
    a_pulse_once: assert property (display_shift_pulse |-> $past(entry_shift) && busy_flag ##1 !display_shift_pulse)
        else $error("shift pulse wrong");
    a_oe_read: assert property ($fell(cs_n) && rd_wr_line |=> serial_data_line_oe)
        else $error("no drive on read");
    a_oe_write: assert property (!rd_wr_line && !cs_n |-> !serial_data_line_oe)
        else $error("drive on write");
    a_first_bit: assert property ($fell(cs_n) && rd_wr_line |=> !serial_data_line_out)
        else $error("unused bit not zero");
endmodule
`default_nettype wire

/* testbench/lsd_host_model.sv */
// host model that shifts serial frames in and out
`timescale 1ns/1ns
`default_nettype none
module lsd_host_model
    import lsd_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // serial link
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe,
    output logic     cs_n,
    output logic     scl,
    output logic     serial_data_line_in,
    output lsd_ctl_t ctl
);
    // idle levels
    initial
    begin
        cs_n = 1'b1;
        scl = 1'b0;
        serial_data_line_in = 1'b0;
        ctl = 3'b000;
    end

    // one frame of n bits, read bits collected
    task automatic xfer(input lsd_ctl_t c, input logic [19:0] d, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(posedge clk_sys);
        ctl <= c;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data_line_in <= d[i];
            repeat (4) @(posedge clk_sys);
            scl <= 1'b1;
            // an undriven line shows the inverse of the last bit seen
            r = {r[14:0], (serial_data_line_oe ? serial_data_line_out : ~r[0])};
            repeat (4) @(posedge clk_sys);
            scl <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        cs_n <= 1'b1;
        serial_data_line_in <= ~serial_data_line_in; // released line does not hold
        repeat (3) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// testbench for the serial command decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import lsd_pkg::*;
;
    localparam int BLINK_BASE_CYC_P = 4;
    localparam int BUSY_CYC_P       = 400;
    localparam lsd_ctl_t C_CMD = 3'b000, C_WDAT = 3'b001, C_RIN = 3'b010;
    localparam lsd_ctl_t C_RKEY = 3'b011, C_STAT = 3'b110, C_RRAM = 3'b111;
    logic       clk_sys, nrst, entry_increment, entry_shift;
    logic [7:0] input_port_lines, key_sense_flags;
    logic [3:0] key_drive_flags;
    logic       serial_data_line_out, serial_data_line_oe, display_shift_pulse, busy_flag;
    logic [5:0] led_output_lines, address_counter;
    wire logic  cs_n, scl, serial_data_line_in;
    lsd_ctl_t   ctl;
    wire logic  register_select_line = ctl.reg_sel;
    wire logic  rd_wr_line = ctl.rd_wr;
    wire logic  transfer_type_bit = ctl.xfer_type;
    int         num_errors, compares, pulses, zeros, edges, ons;
    logic [15:0] r;
    logic [5:0]  prev;

    lsd_decoder #(.BLINK_BASE_CYC_P(BLINK_BASE_CYC_P), .BUSY_CYC_P(BUSY_CYC_P)) dut_u (.*);
    lsd_host_model host_u (
        .clk_sys              (clk_sys),
        .serial_data_line_out (serial_data_line_out),
        .serial_data_line_oe  (serial_data_line_oe),
        .cs_n                 (cs_n),
        .scl                  (scl),
        .serial_data_line_in  (serial_data_line_in),
        .ctl                  (ctl)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (display_shift_pulse === 1'b1) pulses++;

    // ============================================================
    // checks and helpers
    task automatic print_verdict();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle();
        for (int k = 0; k <= 1000; k++)
        begin
            if (busy_flag === 1'b0) return;
            @(posedge clk_sys);
        end
        num_errors++;
        print_verdict();
    endtask
    task automatic op(input lsd_ctl_t c, input logic [15:0] d);
        host_u.xfer(c, {4'h0, d}, 16, r);
        idle(); // host polls busy
    endtask
    task automatic rd(input lsd_ctl_t c, input logic [15:0] exp);
        op(c, 16'h0000);
        chk(r, exp);
    endtask

    // ============================================================
    // main sequence
    initial
    begin
        nrst = 1'b0;
        entry_increment = 1'b1;
        entry_shift = 1'b1;
        input_port_lines = 8'h00;
        key_drive_flags = 4'h0;
        key_sense_flags = 8'h00;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(C_STAT, 16'h0000);
        op(C_CMD, 16'h00d5);
        rd(C_STAT, 16'h0015);
        op(C_WDAT, 16'hfd1a);
        rd(C_STAT, 16'h0016);
        op(C_CMD, 16'h00d5); // address set before read
        entry_increment <= 1'b0;
        rd(C_RRAM, 16'h001a);
        rd(C_STAT, 16'h0014);
        entry_increment <= 1'b1;
        op(C_CMD, 16'h0083); // text RAM target
        op(C_WDAT, 16'h01a5);
        rd(C_STAT, 16'h0004);
        op(C_CMD, 16'h0082); // re-address after write
        op(C_CMD, 16'h0014); // cursor right
        rd(C_RRAM, 16'h00a5);
        entry_shift <= 1'b0;
        op(C_WDAT, 16'h0033); // no shift when disabled
        op(C_CMD, 16'h0010); // cursor left
        rd(C_RRAM, 16'h0033);
        chk(16'(pulses), 16'h0001);
        for (int p = 0; p < 4; p++)
        begin
            op(C_WDAT, 16'h022a | 16'(p << 7));
            zeros = 0;
            edges = 0;
            ons = 0;
            prev = led_output_lines;
            repeat (64)
            begin
                @(posedge clk_sys);
                if (led_output_lines !== prev) edges++;
                if (led_output_lines === 6'h00) zeros++;
                if (led_output_lines === 6'h2a) ons++;
                prev = led_output_lines;
            end
            chk(16'(zeros), (p == 0) ? 16'h0000 : 16'h0020);
            chk(16'(ons), (p == 0) ? 16'h0040 : 16'h0020);
            chk(16'(edges), (p == 0) ? 16'h0000 : 16'(16 >> (p - 1)));
        end
        input_port_lines <= 8'h5c;
        fork
            rd(C_RIN, 16'h005c);
            begin
                repeat (20) @(posedge clk_sys);
                input_port_lines <= 8'ha3;
            end
        join
        key_drive_flags <= 4'h5;
        key_sense_flags <= 8'h14;
        rd(C_RKEY, 16'h0514); // two keys, read as flags only
        host_u.xfer(C_CMD, 20'hf00c7, 20, r);
        idle();
        rd(C_STAT, 16'h0007);
        host_u.xfer(C_CMD, 20'h000c9, 16, r);
        host_u.xfer(C_WDAT, 20'h0001f, 16, r); // refused while busy
        rd(C_STAT, 16'h0049);
        rd(C_STAT, 16'h0009);
        print_verdict();
    end
endmodule

bind lsd_decoder lsd_decoder_mon #(.BLINK_BASE_CYC_P(BLINK_BASE_CYC_P), .BUSY_CYC_P(BUSY_CYC_P)) mon_u (.*);
`default_nettype wire
